// >>> verilog/net_status_map.vh
// register offsets, bit positions, commands and timing for the status block
`ifndef NET_STATUS_MAP_VH
`define NET_STATUS_MAP_VH
`define OFS_STATUS      6'h00
`define OFS_DIAG        6'h02
`define ST_POR          4
`define ST_RECONFIG_FLAG        2
`define ST_TMA          1
`define ST_TA           0
`define ST_RSVD_ONES    8'he0
`define MSK_EXCESS_NAK_FLAG      3
`define MSK_RECONFIG_FLAG       2
`define MSK_NXTERR      1
`define MSK_TA          0
`define DG_MYRECON      7
`define DG_DUPLICATE_ID_FLAG        6
`define DG_RX_ACTIVITY_FLAG       5
`define DG_TOKEN        4
`define DG_EXCESS_NAK_FLAG       3
`define DG_TENT         2
`define DG_NXTERR       1
`define CMD_CANCEL      8'h01
`define CMD_SEND        8'h03
`define CMD_NXT_CLR     8'h09
`define CMD_POR_CLR     8'h0e
`define CMD_RECONFIG_FLAG_CLR   8'h16
`define NODE_ID_NONE    8'h00
`define BOOT_MARK       8'hd1
`define TEMP_RST_NS     100
`define CLK_NS          10
`define SETTLE_NS_25M   1000
`define BOOT_NS_25M     10000
`define NAK_LIM_LO      8'd4
`define NAK_LIM_HI      8'd128
`define RATE_125        2'b00
`define RATE_25         2'b01
`define RATE_5          2'b10
`endif

// >>> verilog/reset_sequencer.v
// software reset generation, settle and boot-record timing
`include "net_status_map.vh"
module reset_sequencer #(
    parameter integer TEMP_CYC   = (`TEMP_RST_NS + `CLK_NS - 1) / `CLK_NS,
    parameter integer SETTLE_CYC = `SETTLE_NS_25M / `CLK_NS,
    parameter integer BOOT_CYC   = `BOOT_NS_25M / `CLK_NS,
    parameter integer CW         = 16
) (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       perm_rst,
    input  wire       temp_trig,
    input  wire [1:0] rate_sel,
    output wire       sw_rst,
    output wire       comm_ready,
    output reg        boot_pulse
);
    localparam S_IDLE  = 2'd0;
    localparam S_RST   = 2'd1;
    localparam S_SETL  = 2'd2;
    localparam S_BOOT  = 2'd3;
    reg [1:0]    st_q;
    reg [CW-1:0] cnt_q;
    reg          temp_q;
    reg [CW-1:0] temp_cnt_q;
    // the settle delay scales with network rate; the temporary reset length does not
    function [CW-1:0] scale;
        input [CW-1:0] base;
        input [1:0]    rs;
        begin
            case (rs)
                `RATE_125: scale = {base[CW-2:0], 1'b0};
                `RATE_5:   scale = {1'b0, base[CW-1:1]};
                default:   scale = base;
            endcase
        end
    endfunction
    assign sw_rst = perm_rst | temp_q;
    assign comm_ready = (st_q == S_BOOT) | (st_q == S_IDLE);
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            temp_q     <= 1'b0;
            temp_cnt_q <= {CW{1'b0}};
        end else if (temp_trig) begin
            temp_q     <= 1'b1;
            temp_cnt_q <= TEMP_CYC[CW-1:0] - 1'b1;
        end else if (temp_cnt_q != {CW{1'b0}}) begin
            temp_cnt_q <= temp_cnt_q - 1'b1;
        end else begin
            temp_q <= 1'b0;
        end
    end
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q       <= S_RST;
            cnt_q      <= {CW{1'b0}};
            boot_pulse <= 1'b0;
        end else begin
            boot_pulse <= 1'b0;
            if (sw_rst) begin
                st_q  <= S_RST;
                cnt_q <= {CW{1'b0}};
            end else begin
                case (st_q)
                    S_RST: begin
                        st_q  <= S_SETL;
                        cnt_q <= {CW{1'b0}};
                    end
                    S_SETL: begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q >= scale(BOOT_CYC[CW-1:0], rate_sel)) begin
                            st_q       <= S_BOOT;
                            boot_pulse <= 1'b1;
                        end
                    end
                    S_BOOT: st_q <= S_IDLE;
                    S_IDLE: st_q <= S_IDLE;
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end
    wire unused_settle = (SETTLE_CYC == 0);
endmodule

// >>> verilog/nak_counter.v
// counts negative replies to free-buffer enquiries
`include "net_status_map.vh"
module nak_counter (
    input  wire clk_sys,
    input  wire rst_b,
    input  wire clr,
    input  wire nak_seen,
    input  wire nak_128_sel,
    output wire limit_hit
);
    reg [7:0] cnt_q;
    wire [7:0] lim = nak_128_sel ? `NAK_LIM_HI : `NAK_LIM_LO;
    assign limit_hit = nak_seen & (cnt_q == lim - 8'd1);
    always @(posedge clk_sys) begin
        if (!rst_b || clr)
            cnt_q <= 8'h00;
        else if (nak_seen && cnt_q != lim - 8'd1)
            cnt_q <= cnt_q + 8'd1;
        else if (nak_seen)
            cnt_q <= 8'h00;
    end
endmodule

// >>> verilog/net_status_diag_reset_regs.v
// status, mask, diagnostic and software reset registers of the controller
`include "net_status_map.vh"

module net_status_diag_reset_regs #(
    parameter integer BOOT_CYC = `BOOT_NS_25M / `CLK_NS
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [5:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        reset_ctrl_bit,
    input  wire        init_mode_bit,
    input  wire        transmit_enable_bit,
    input  wire [7:0]  node_id_reg,
    input  wire        cfg_reg_write,
    input  wire [1:0]  rate_sel,
    input  wire        tx_buffer_mode,
    input  wire        one_shot_option,
    input  wire        common_irq_enable,
    input  wire        nak_128_sel,
    input  wire        ev_reconfig,
    input  wire        ev_local_reconfig,
    input  wire        ev_tx_acked,
    input  wire        ev_tx_done,
    input  wire        ev_dup_id,
    input  wire        ev_own_token,
    input  wire        ev_rx_activity,
    input  wire        ev_token_other,
    input  wire        ev_nak,
    input  wire        ev_tentative_match,
    input  wire        ev_next_node_err,
    output wire        sw_rst,
    output wire        comm_ready,
    output reg         tx_busy,
    output wire        irq_req,
    output reg         boot_wr,
    output reg  [7:0]  boot_addr,
    output reg  [7:0]  boot_data
);
    reg  [7:0] cmd;
    reg        cmd_wr;
    reg        init_mode_q;
    reg        transmit_enable_bit_q;
    reg        por_q;
    reg        reconfig_flag_q;
    reg        tx_acknowledged_q;
    reg        tx_available_q;
    reg        continuous_q;
    reg  [3:0] mask_q;
    reg  [7:0] diag_q;
    reg        dup_first_q;
    reg        boot_second_q;

    wire       temp_trig;
    wire       boot_pulse;
    wire       nak_hit;
    // decode of the two word offsets
    wire       wr_status = reg_wr && reg_addr == `OFS_STATUS;
    wire       wr_diag   = reg_wr && reg_addr == `OFS_DIAG;
    wire       rd_diag   = reg_rd && reg_addr == `OFS_DIAG;
    wire       rd_status = reg_rd && reg_addr == `OFS_STATUS;
    wire       perm      = reset_ctrl_bit
                         | (node_id_reg == `NODE_ID_NONE);
    // three ways to start a temporary reset
    wire       init_flip   = init_mode_bit != init_mode_q;
    wire       transmit_enable_bit_rise   = transmit_enable_bit & ~transmit_enable_bit_q;
    wire       cfg_in_init = init_mode_bit & cfg_reg_write;

    // commands come only from the low byte of a write at the diag offset
    function is_cmd;
        input       wr;
        input [7:0] code;
        input [7:0] want;
        begin
            is_cmd = wr && (code == want);
        end
    endfunction

    wire       cmd_send      = is_cmd(cmd_wr, cmd, `CMD_SEND);
    wire       cmd_cancel    = is_cmd(cmd_wr, cmd, `CMD_CANCEL);
    wire       cmd_por_clr   = is_cmd(cmd_wr, cmd, `CMD_POR_CLR);
    wire       cmd_reconfig_flag_clr = is_cmd(cmd_wr, cmd, `CMD_RECONFIG_FLAG_CLR);
    wire       cmd_nxt_clr   = is_cmd(cmd_wr, cmd, `CMD_NXT_CLR);

    // reserved status bits always read back as ones
    wire [7:0] status_word = `ST_RSVD_ONES
                           | {3'b000, por_q, 1'b0, reconfig_flag_q,
                              tx_acknowledged_q, tx_available_q};

    always @* begin
        cmd    = reg_wdata[7:0];
        cmd_wr = wr_diag;
    end

    // edges of the mode bits; one cycle stale so compare to captured copy
    assign temp_trig = init_flip | transmit_enable_bit_rise | cfg_in_init;

    // captured copies for edge detection
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            init_mode_q <= 1'b0;
            transmit_enable_bit_q      <= 1'b0;
        end else begin
            init_mode_q <= init_mode_bit;
            transmit_enable_bit_q      <= transmit_enable_bit;
        end
    end

    // sequencer owns both the held and the self-releasing reset
    reset_sequencer #(
        .BOOT_CYC   (BOOT_CYC)
    ) u_seq (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .perm_rst   (perm),
        .temp_trig  (temp_trig),
        .rate_sel   (rate_sel),
        .sw_rst     (sw_rst),
        .comm_ready (comm_ready),
        .boot_pulse (boot_pulse)
    );

    // excess-nak threshold is counted apart from the flag
    nak_counter u_nak (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .clr         (sw_rst),
        .nak_seen    (ev_nak),
        .nak_128_sel (nak_128_sel),
        .limit_hit   (nak_hit)
    );

    // status flags; set wins over command clear in the same cycle, except send, which beats ev_tx_done on tx_available_q
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            por_q             <= 1'b1;
            reconfig_flag_q   <= 1'b0;
            tx_acknowledged_q <= 1'b0;
            tx_available_q    <= 1'b1;
            continuous_q      <= 1'b0;
            tx_busy           <= 1'b0;
        end else if (sw_rst) begin
            por_q             <= 1'b1;
            reconfig_flag_q   <= 1'b0;
            tx_acknowledged_q <= 1'b0;
            tx_available_q    <= 1'b1;
            continuous_q      <= 1'b0;
            tx_busy           <= 1'b0;
        end else begin
            if (cmd_por_clr)
                por_q <= 1'b0;
            if (ev_reconfig)
                reconfig_flag_q <= 1'b1;
            else if (cmd_reconfig_flag_clr)
                reconfig_flag_q <= 1'b0;
            if (ev_tx_acked)
                tx_acknowledged_q <= 1'b1;
            else if (cmd_send)
                tx_acknowledged_q <= 1'b0;
            // remote send without one-shot keeps going until cancelled or until the one-shot option is set
            if (cmd_send) begin
                tx_available_q <= 1'b0;
                tx_busy        <= 1'b1;
                continuous_q   <= tx_buffer_mode & ~one_shot_option;
            end else if (cmd_cancel) begin
                tx_available_q <= 1'b1;
                tx_busy        <= 1'b0;
                continuous_q   <= 1'b0;
            end else if (continuous_q) begin
                if (one_shot_option) begin
                    continuous_q   <= 1'b0;
                    tx_available_q <= 1'b1;
                    tx_busy        <= 1'b0;
                end
            end else if (tx_busy && ev_tx_done) begin
                tx_available_q <= 1'b1;
                tx_busy        <= 1'b0;
            end
        end
    end

    // mask register is cleared by any reset
    always @(posedge clk_sys) begin
        if (!rst_b || sw_rst)
            mask_q <= 4'h0;
        else if (wr_status)
            mask_q <= reg_wdata[3:0];
    end

    // each mask bit gates one event source
    wire       irq_excess_nak_flag = mask_q[`MSK_EXCESS_NAK_FLAG] & diag_q[`DG_EXCESS_NAK_FLAG];
    wire       irq_reconfig_flag  = mask_q[`MSK_RECONFIG_FLAG]  & reconfig_flag_q;
    wire       irq_nxterr = mask_q[`MSK_NXTERR] & diag_q[`DG_NXTERR];
    wire       irq_ta     = mask_q[`MSK_TA]     & tx_available_q;
    assign irq_req = common_irq_enable
                   & (irq_excess_nak_flag | irq_reconfig_flag | irq_nxterr | irq_ta);

    // remembers that the first own token since going online was seen
    always @(posedge clk_sys) begin
        if (!rst_b || sw_rst)
            dup_first_q <= 1'b0;
        else if (!transmit_enable_bit)
            dup_first_q <= 1'b0;
        else if (ev_own_token)
            dup_first_q <= 1'b1;
    end

    // diagnostics; a read clears all but the excess-nak and next-node error bits unless an event lands in the same cycle
    always @(posedge clk_sys) begin
        if (!rst_b || sw_rst) begin
            diag_q <= 8'h00;
        end else begin
            if (rd_diag) begin
                diag_q[`DG_MYRECON] <= 1'b0;
                diag_q[`DG_DUPLICATE_ID_FLAG]   <= 1'b0;
                diag_q[`DG_RX_ACTIVITY_FLAG]  <= 1'b0;
                diag_q[`DG_TOKEN]   <= 1'b0;
                diag_q[`DG_TENT]    <= 1'b0;
            end
            // command clears; the sets below win in the same cycle
            if (cmd_por_clr)
                diag_q[`DG_EXCESS_NAK_FLAG] <= 1'b0;
            if (cmd_nxt_clr)
                diag_q[`DG_NXTERR] <= 1'b0;
            if (ev_local_reconfig)
                diag_q[`DG_MYRECON] <= 1'b1;
            if (!transmit_enable_bit && ev_dup_id)
                diag_q[`DG_DUPLICATE_ID_FLAG] <= 1'b1;
            // first own token after going online is swallowed
            if (transmit_enable_bit && ev_own_token && dup_first_q)
                diag_q[`DG_DUPLICATE_ID_FLAG] <= 1'b1;
            if (ev_rx_activity)
                diag_q[`DG_RX_ACTIVITY_FLAG] <= 1'b1;
            if (ev_token_other)
                diag_q[`DG_TOKEN] <= 1'b1;
            if (nak_hit)
                diag_q[`DG_EXCESS_NAK_FLAG] <= 1'b1;
            if (ev_tentative_match)
                diag_q[`DG_TENT] <= 1'b1;
            if (ev_next_node_err)
                diag_q[`DG_NXTERR] <= 1'b1;
            diag_q[0] <= 1'b0;
        end
    end

    // boot record: two RAM byte writes after reset settles
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            boot_wr       <= 1'b0;
            boot_addr     <= 8'h00;
            boot_data     <= 8'h00;
            boot_second_q <= 1'b0;
        end else begin
            boot_wr       <= boot_pulse | boot_second_q;
            boot_second_q <= boot_pulse;
            if (boot_pulse) begin
                boot_addr <= 8'h00;
                boot_data <= `BOOT_MARK;
            end else if (boot_second_q) begin
                boot_addr <= 8'h01;
                boot_data <= node_id_reg;
            end
        end
    end

    // registered read data; unmapped offsets read zero
    always @(posedge clk_sys) begin
        if (!rst_b)
            reg_rdata <= 16'h0000;
        else if (rd_status)
            reg_rdata <= {8'h00, status_word};
        else if (rd_diag)
            reg_rdata <= {8'h00, diag_q};
        else if (reg_rd)
            reg_rdata <= 16'h0000;
    end

endmodule

// >>> verification/net_status_chk.sv
// port assertions for the status, diagnostic and reset register block
module net_status_chk #(
    parameter integer BOOT_CYC = 1000
) (
    input logic        clk_sys,
    input logic        rst_b,
    input logic [5:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata,
    input logic        reset_ctrl_bit,
    input logic        init_mode_bit,
    input logic [7:0]  node_id_reg,
    input logic        common_irq_enable,
    input logic        sw_rst,
    input logic        tx_busy,
    input logic        irq_req,
    input logic        boot_wr,
    input logic [7:0]  boot_addr,
    input logic [7:0]  boot_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire perm = reset_ctrl_bit || node_id_reg == 8'h00;
    wire cmd  = reg_wr && reg_addr == 6'h02 && !sw_rst;

    property p_perm_hold;
        perm && $past(perm) |-> sw_rst;
    endproperty
    a_perm_hold: assert property (p_perm_hold) else $error("reset not held");
    property p_temp_len;
        $rose(sw_rst) && !perm |-> sw_rst [*8] ##[1:4] !sw_rst;
    endproperty
    a_temp_len: assert property (p_temp_len) else $error("temp reset length");
    property p_init_trig;
        $changed(init_mode_bit) |-> ##[0:2] sw_rst;
    endproperty
    a_init_trig: assert property (p_init_trig) else $error("no temp reset");
    property p_rd_reset;
        reg_rd && reg_addr == 6'h00 && sw_rst && $past(sw_rst)
            |=> reg_rdata == 16'h00f1;
    endproperty
    a_rd_reset: assert property (p_rd_reset) else $error("status in reset");
    property p_send;
        cmd && reg_wdata[7:0] == 8'h03 |=> tx_busy;
    endproperty
    a_send: assert property (p_send) else $error("send not busy");
    property p_cancel;
        cmd && reg_wdata[7:0] == 8'h01 |=> !tx_busy;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel still busy");
    property p_irq_gate;
        !common_irq_enable |-> !irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
    property p_irq_rst;
        sw_rst && $past(sw_rst) |-> !irq_req;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("mask not cleared");
    property p_boot;
        boot_wr && boot_addr == 8'h00 |-> boot_data == 8'hd1 ##1
            boot_wr && boot_addr == 8'h01 && boot_data == node_id_reg;
    endproperty
    a_boot: assert property (p_boot) else $error("boot record");
    c_boot: cover property (boot_wr);
    c_irq: cover property ($rose(irq_req));
    c_temp: cover property ($rose(sw_rst) && !perm);
endmodule

// >>> verification/host_model.sv
// host model: one register transfer at a time on the parallel bus
module host_model (
    input  logic        clk_sys,
    input  logic        comm_ready,
    input  logic [15:0] reg_rdata,
    output logic [5:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 6'h3f;
        reg_wdata = 16'h5a5a;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // early writes after a software reset may be dropped, so hold off
    task wr(input logic [5:0] a, input logic [15:0] v);
        int n;
        n = 0;
        while (comm_ready !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys) begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
        end
        @(posedge clk_sys) begin
            reg_wr <= 1'b0;
            reg_wdata <= ~v;
        end
        #1;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] v);
        @(posedge clk_sys) begin
            reg_addr <= a;
            reg_rd <= 1'b1;
        end
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule

// >>> verification/net_status_diag_reset_regs_tb_top.sv
// testbench for the status, diagnostic and reset register block
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module net_status_diag_reset_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst_b, reset_ctrl_bit, init_mode_bit;
    logic        transmit_enable_bit, cfg_reg_write, tx_buffer_mode;
    logic        one_shot_option, common_irq_enable, nak_128_sel;
    logic [7:0]  node_id_reg;
    logic [1:0]  rate_sel;
    logic [10:0] evv;
    logic [15:0] d, c;
    wire  [5:0]  reg_addr;
    wire  [15:0] reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, sw_rst, comm_ready, tx_busy, irq_req;
    wire         boot_wr;
    wire  [7:0]  boot_addr, boot_data;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cy[3];
    int          ei[6] = '{1, 4, 4, 6, 7, 9};
    int          db[6] = '{7, 6, 6, 5, 4, 2};

    net_status_diag_reset_regs #(.BOOT_CYC(10)) i_dut (
        .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reset_ctrl_bit, .init_mode_bit, .transmit_enable_bit,
        .node_id_reg, .cfg_reg_write, .rate_sel, .tx_buffer_mode,
        .one_shot_option, .common_irq_enable, .nak_128_sel,
        .ev_reconfig(evv[0]), .ev_local_reconfig(evv[1]),
        .ev_tx_acked(evv[2]), .ev_tx_done(evv[3]), .ev_dup_id(evv[4]),
        .ev_own_token(evv[5]), .ev_rx_activity(evv[6]),
        .ev_token_other(evv[7]), .ev_nak(evv[8]),
        .ev_tentative_match(evv[9]), .ev_next_node_err(evv[10]),
        .sw_rst, .comm_ready, .tx_busy, .irq_req, .boot_wr, .boot_addr,
        .boot_data);
    host_model i_host (.clk_sys, .comm_ready, .reg_rdata, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd);

    function automatic logic [15:0] stv(input logic [2:0] f);
        return 16'h00e0 | {13'h0000, f};
    endfunction
    // with only ta and next-node error pending
    function automatic logic irqv(input logic [15:0] v);
        return v[4] & (v[0] | v[1]);
    endfunction
    task ev(input int i);
        @(posedge clk_sys) evv[i] <= 1'b1;
        @(posedge clk_sys) evv <= '0;
        #1;
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        complete_run;
    end
    initial begin
        rst_b = 1'b0;
        reset_ctrl_bit = 1'b0;
        init_mode_bit = 1'b0;
        transmit_enable_bit = 1'b0;
        cfg_reg_write = 1'b0;
        tx_buffer_mode = 1'b0;
        one_shot_option = 1'b0;
        common_irq_enable = 1'b0;
        nak_128_sel = 1'b0;
        node_id_reg = 8'h05;
        rate_sel = 2'b01;
        evv = '0;
        c = $urandom(51415);
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        i_host.rd(6'h00, d);
        `CHK("status", 16'h00f1, d)
        i_host.rd(6'h02, d);
        `CHK("diag", 16'h0000, d)
        i_host.rd(6'h04, d);
        `CHK("unmapped", 16'h0000, d)
        i_host.wr(6'h02, 16'h000e);
        i_host.rd(6'h00, d);
        `CHK("por clr", stv(3'b001), d)
        i_host.wr(6'h02, 16'h0003);
        i_host.rd(6'h00, d);
        `CHK("send", stv(3'b000), d)
        `CHK("busy", 1'b1, tx_busy)
        ev(2);
        ev(3);
        i_host.rd(6'h00, d);
        `CHK("acked", stv(3'b011), d)
        i_host.wr(6'h02, 16'h0003);
        i_host.wr(6'h02, 16'h0001);
        i_host.rd(6'h00, d);
        `CHK("cancel", stv(3'b001), d)
        @(posedge clk_sys) tx_buffer_mode <= 1'b1;
        i_host.wr(6'h02, 16'h0003);
        ev(3);
        i_host.rd(6'h00, d);
        `CHK("continuous", stv(3'b000), d)
        @(posedge clk_sys) one_shot_option <= 1'b1;
        i_host.rd(6'h00, d);
        `CHK("one shot", stv(3'b001), d)
        @(posedge clk_sys) tx_buffer_mode <= 1'b0;
        ev(0);
        i_host.rd(6'h00, d);
        `CHK("reconfig_flag", stv(3'b101), d)
        i_host.wr(6'h02, 16'h0016);
        i_host.rd(6'h00, d);
        `CHK("reconfig_flag clr", stv(3'b001), d)
        for (int k = 0; k < 6; k++) begin
            ev(ei[k]);
            i_host.rd(6'h02, d);
            `CHK("diag set", 16'h0001 << db[k], d)
            i_host.rd(6'h02, d);
            `CHK("diag rdclr", 16'h0000, d)
        end
        // online: first own token is ignored, the second one counts
        @(posedge clk_sys) transmit_enable_bit <= 1'b1;
        repeat (14) @(posedge clk_sys);
        ev(5);
        i_host.rd(6'h02, d);
        `CHK("own first", 16'h0000, d)
        ev(5);
        i_host.rd(6'h02, d);
        `CHK("own token", 16'h0040, d)
        @(posedge clk_sys) transmit_enable_bit <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys) nak_128_sel <= s[0];
            repeat (s ? 127 : 3) ev(8);
            i_host.rd(6'h02, d);
            `CHK("nak early", 16'h0000, d)
            ev(8);
            i_host.rd(6'h02, d);
            i_host.rd(6'h02, d);
            `CHK("nak sticky", 16'h0008, d)
            i_host.wr(6'h02, 16'h000e);
            i_host.rd(6'h02, d);
            `CHK("nak clr", 16'h0000, d)
        end
        ev(10);
        i_host.rd(6'h02, d);
        i_host.rd(6'h02, d);
        `CHK("next err", 16'h0002, d)
        for (int k = 0; k < 16; k++) begin
            c = $urandom;
            @(posedge clk_sys) common_irq_enable <= c[4];
            i_host.wr(6'h00, {12'h000, c[3:0]});
            `CHK("irq", irqv(c), irq_req)
        end
        i_host.wr(6'h02, 16'h0009);
        i_host.rd(6'h02, d);
        `CHK("next clr", 16'h0000, d)
        @(posedge clk_sys) reset_ctrl_bit <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("hold", 1'b1, sw_rst)
        i_host.rd(6'h00, d);
        `CHK("sw status", 16'h00f1, d)
        `CHK("sw mask", 1'b0, irq_req)
        @(posedge clk_sys) reset_ctrl_bit <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            c = $urandom;
            @(posedge clk_sys) rate_sel <= r[1:0];
            node_id_reg <= 8'h00;
            repeat (3) @(posedge clk_sys);
            #1 `CHK("id zero", 1'b1, sw_rst)
            @(posedge clk_sys) node_id_reg <= c[7:0] | 8'h01;
            cy[r] = 0;
            while (boot_wr !== 1'b1 && cy[r] < 5000) begin
                @(posedge clk_sys);
                #1 cy[r]++;
            end
            `CHK("boot addr", 8'h00, boot_addr)
            `CHK("boot mark", 8'hd1, boot_data)
            @(posedge clk_sys);
            #1 `CHK("boot id", c[7:0] | 8'h01, boot_data)
        end
        `CHK("rate", 1'b1, cy[0] > cy[1] && cy[2] < cy[1])
        // trigger kinds: init change, enable rise, config write; enable fall must not trigger
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys) case (k)
                0: init_mode_bit <= 1'b1;
                1, 3: transmit_enable_bit <= k == 1;
                default: cfg_reg_write <= 1'b1;
            endcase
            @(posedge clk_sys) cfg_reg_write <= 1'b0;
            @(posedge clk_sys);
            #1 `CHK("temp rst", k != 3, sw_rst)
            repeat (13) @(posedge clk_sys);
            #1 `CHK("temp end", 1'b0, sw_rst)
        end
        complete_run;
    end
endmodule
bind net_status_diag_reset_regs net_status_chk #(.BOOT_CYC(BOOT_CYC)) i_chk (
    .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reset_ctrl_bit, .init_mode_bit, .node_id_reg, .common_irq_enable,
    .sw_rst, .tx_busy, .irq_req, .boot_wr, .boot_addr, .boot_data);
